/* rtl/catc_term_ctrl.sv */
// command/address bus termination decision and strength control
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - strength for clock, chip select and CA comes from value field bits 6:4.
// - after reset field reads disabled; disabled means no termination anywhere.
// - termination stays unchanged through power-down and self-refresh power-down.
// - bond option low means CA never terminated.
// - bond high, field enabled: CA on unless disable bit; clock, select always on.
// - bond low, field enabled: clock and select on only by their force bits.
// - codes 001..110 select reference divided by one through six.
// - a new value is applied within the update time after a change.
module catc_term_ctrl
	import catc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic setting_wr,
	input wire logic [7:0] setting_op,
	input wire logic override_wr,
	input wire logic [7:0] override_op,
	input wire logic ca_term_bond_option,
	input wire logic power_down,
	output logic [2:0] ca_term_value_field,
	output logic ca_term_disable_bit,
	output logic clk_term_force_bit,
	output logic cs_term_force_bit,
	output catc_pkg::catc_term_en_t term_en,
	output catc_pkg::catc_div_t term_div,
	output logic update_busy
);
	catc_state_t state;
	catc_state_t next_state;
	logic [3:0] upd_cnt;
	logic [3:0] next_upd_cnt;
	logic [2:0] next_value;
	logic field_en;
	catc_div_t field_div;
	catc_term_en_t next_term_en;
	logic value_change;

	// new field value taken from the setting operand
	assign next_value = setting_op[VAL_MSB:VAL_LSB];
	assign value_change = setting_wr && (next_value != ca_term_value_field);

	// mode-register fields; power_down deliberately does not touch them
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ca_term_value_field <= VAL_RESET;
			ca_term_disable_bit <= OVR_RESET[CA_DIS_POS];
			clk_term_force_bit <= OVR_RESET[CK_FORCE_POS];
			cs_term_force_bit <= OVR_RESET[CS_FORCE_POS];
		end else begin
			if (setting_wr) begin
				ca_term_value_field <= next_value;
			end
			if (override_wr) begin
				ca_term_disable_bit <= override_op[CA_DIS_POS];
				clk_term_force_bit <= override_op[CK_FORCE_POS];
				cs_term_force_bit <= override_op[CS_FORCE_POS];
			end
		end
	end

	// strength decode of the stored field, shared by the enables and the divider output
	catc_strength_dec u_dec (
		.code(ca_term_value_field),
		.enabled(field_en),
		.div(field_div)
	);

	// state table: field disabled forces all off, bond gates CA; one assignment keeps one driver
	assign next_term_en = '{
		ca: field_en && ca_term_bond_option && !ca_term_disable_bit,
		ck: field_en && (ca_term_bond_option || clk_term_force_bit),
		cs: field_en && (ca_term_bond_option || cs_term_force_bit)
	};

	// update timer: a value change settles inside the update window
	// a new value during the window restarts it; rewriting the same value does not
	always_comb begin
		next_state = state;
		next_upd_cnt = upd_cnt;
		case (state)
			ST_IDLE: begin
				if (value_change) begin
					next_state = ST_WAIT;
					next_upd_cnt = UPDATE_CNT - 4'h1;
				end
			end
			ST_WAIT: begin
				if (value_change) begin
					next_upd_cnt = UPDATE_CNT - 4'h1;
				end else if (upd_cnt == 4'h0) begin
					next_state = ST_IDLE;
				end else begin
					next_upd_cnt = upd_cnt - 4'h1;
				end
			end
			default: begin
				next_state = ST_IDLE;
				next_upd_cnt = 4'h0;
			end
		endcase
	end

	// timer registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			upd_cnt <= 4'h0;
		end else begin
			state <= next_state;
			upd_cnt <= next_upd_cnt;
		end
	end

	// outputs follow registered settings one cycle later, well within the window
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			term_en <= '0;
			term_div <= '0;
		end else begin
			term_en <= next_term_en;
			term_div <= field_div;
		end
	end

	// window flag straight from the state register, so it cannot glitch
	assign update_busy = (state == ST_WAIT);

	// checks: every property samples on the rising edge and rests while reset is held
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// bond low for two samples: the registered CA enable must be open by then
	bond_low_ca_a: assert property (!ca_term_bond_option ##1 !ca_term_bond_option |-> !term_en.ca)
		else $error("CA terminated with bond option low");

	// a field that was disabled one cycle back leaves every group open
	disabled_off_a: assert property ($past(!field_en) |-> term_en == '0)
		else $error("termination on while field disabled");

	// bond high: clock and select follow the field, their force bits do not matter
	bond_high_on_a: assert property (field_en && ca_term_bond_option |=> term_en.ck && term_en.cs)
		else $error("clock or select off with bond high");

	// bond high: CA is the inverse of the disable bit
	ca_dis_a: assert property (field_en && ca_term_bond_option |=> term_en.ca == !$past(ca_term_disable_bit))
		else $error("CA state does not follow disable bit");

	// bond low: clock and select obey only their own force bits
	force_bits_a: assert property (field_en && !ca_term_bond_option
		|=> term_en.ck == $past(clk_term_force_bit) && term_en.cs == $past(cs_term_force_bit))
		else $error("force bits not honoured with bond low");

	// entering power-down leaves the termination alone; a write one cycle back
	// is still travelling into the output register, so it is excluded
	pd_hold_a: assert property ($rose(power_down) && $past(!setting_wr && !override_wr)
		&& $stable(ca_term_bond_option) |=> $stable(term_en) && $stable(term_div))
		else $error("termination changed on power-down");

	// with no write and a steady bond the outputs do not move, power-down or not
	steady_hold_a: assert property ($past(!setting_wr && !override_wr) && $stable(ca_term_bond_option)
		|=> $stable(term_en) && $stable(term_div))
		else $error("termination moved without a write");

	// a written value reaches the strength output two edges after the write
	update_done_a: assert property (setting_wr ##1 !setting_wr [*2] |-> term_div == field_div)
		else $error("new value not applied in time");

	// decode spot checks at both ends of the strength range
	div_decode_a: assert property (setting_wr && setting_op[VAL_MSB:VAL_LSB] == VAL_DIV6
		|=> ##1 term_div == 6'h20)
		else $error("code 110 not decoded to reference/6");
	div1_decode_a: assert property (setting_wr && setting_op[VAL_MSB:VAL_LSB] == VAL_DIV1
		|=> ##1 term_div == 6'h01)
		else $error("code 001 not decoded to the full reference");

	// the spare code behaves as disabled
	rsvd_off_a: assert property (setting_wr && setting_op[VAL_MSB:VAL_LSB] == VAL_RSVD
		|=> ##1 term_en == '0 && term_div == '0)
		else $error("code 111 not treated as disabled");

	// the field register takes operand bits 6:4 on a write and holds otherwise
	field_write_a: assert property (setting_wr
		|=> ca_term_value_field == $past(setting_op[VAL_MSB:VAL_LSB]))
		else $error("value field does not follow its write");
	field_hold_a: assert property (!setting_wr |=> $stable(ca_term_value_field))
		else $error("value field changed without a write");

	// override bits follow their write and hold otherwise
	ovr_write_a: assert property (override_wr |=> ca_term_disable_bit == $past(override_op[CA_DIS_POS])
		&& clk_term_force_bit == $past(override_op[CK_FORCE_POS])
		&& cs_term_force_bit == $past(override_op[CS_FORCE_POS]))
		else $error("override bits do not follow their write");
	ovr_hold_a: assert property (!override_wr
		|=> $stable({ca_term_disable_bit, clk_term_force_bit, cs_term_force_bit}))
		else $error("override bits changed without a write");

	// an enabled group needs a strength; an empty divider would leave it floating
	en_needs_div_a: assert property (term_en != '0 |-> term_div != '0)
		else $error("termination on with no strength selected");

	// a value change opens the update window on the next cycle
	busy_start_a: assert property (setting_wr && setting_op[VAL_MSB:VAL_LSB] != ca_term_value_field
		|=> update_busy)
		else $error("update window not opened by a value change");

	// the window lasts five cycles: no shorter, and no longer without a new change
	busy_len_a: assert property ($rose(update_busy) |-> update_busy [*5])
		else $error("update window shorter than expected");
	busy_end_a: assert property ((update_busy && !value_change) [*5] |=> !update_busy)
		else $error("update window longer than expected");

	// main scenarios: all on, clock only, select only, on in power-down, window closing
	cov_full_on_c: cover property (term_en == 3'b111);
	cov_ck_only_c: cover property (term_en == 3'b010);
	cov_cs_only_c: cover property (term_en == 3'b001);
	cov_pd_on_c: cover property (power_down && term_en.ca);
	cov_update_c: cover property ($fell(update_busy));
endmodule
`default_nettype wire

/* include/catc_pkg.sv */
// shared constants and types for the command-bus termination control
package catc_pkg;
	// termination value field codes
	localparam logic [2:0] VAL_OFF = 3'h0;
	localparam logic [2:0] VAL_DIV1 = 3'h1;
	localparam logic [2:0] VAL_DIV2 = 3'h2;
	localparam logic [2:0] VAL_DIV3 = 3'h3;
	localparam logic [2:0] VAL_DIV4 = 3'h4;
	localparam logic [2:0] VAL_DIV5 = 3'h5;
	localparam logic [2:0] VAL_DIV6 = 3'h6;
	localparam logic [2:0] VAL_RSVD = 3'h7;
	// field positions in the mode-register operand
	localparam int VAL_LSB = 4;
	localparam int VAL_MSB = 6;
	localparam int CK_FORCE_POS = 3;
	localparam int CS_FORCE_POS = 4;
	localparam int CA_DIS_POS = 5;
	localparam logic [2:0] VAL_RESET = 3'h0;
	localparam logic [7:0] OVR_RESET = 8'h00;
	// update time: figure not yet specified, plain default in ns
	localparam int UPDATE_NS = 20;
	localparam int CLK_PERIOD_PS = 4000;
	localparam int UPDATE_CYC_RAW = (UPDATE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int UPDATE_CYC = (UPDATE_CYC_RAW < 1) ? 1 : UPDATE_CYC_RAW;
	localparam logic [3:0] UPDATE_CNT = 4'(UPDATE_CYC);

	// termination enable per input group
	typedef struct packed {
		logic ca;
		logic ck;
		logic cs;
	} catc_term_en_t;

	// one-hot divider of the reference resistor, bit n-1 selects reference/n
	typedef logic [5:0] catc_div_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01
	} catc_state_t;
endpackage

/* rtl/catc_strength_dec.sv */
// decode of the termination value field into a reference divider
`timescale 1ns/1ps
`default_nettype none
module catc_strength_dec
	import catc_pkg::*;
(
	input wire logic [2:0] code,
	output logic enabled,
	output catc_pkg::catc_div_t div
);
	// 000 and 111 have no strength; both read as disabled
	assign enabled = (code != VAL_OFF) && (code != VAL_RSVD);
	// one-hot divider select, code n gives reference/n
	assign div = enabled ? catc_div_t'(6'h01 << (code - 3'h1)) : 6'h00;
endmodule
`default_nettype wire

/* dv/catc_ctrl_model.sv */
// controller model writing the termination mode registers
`timescale 1ns/1ps
`default_nettype none
module catc_ctrl_model (
	input wire logic clk,
	output logic setting_wr,
	output logic [7:0] setting_op,
	output logic override_wr,
	output logic [7:0] override_op
);
	import catc_pkg::*;
	initial begin
		setting_wr = 1'b0;
		override_wr = 1'b0;
		setting_op = 8'h00;
		override_op = 8'h00;
	end
	// one-cycle write, sel high picks the setting register
	task automatic wr(input logic sel, input logic [7:0] op);
		@(posedge clk);
		setting_wr <= sel;
		override_wr <= !sel;
		setting_op <= sel ? op : setting_op;
		override_op <= sel ? override_op : op;
		@(posedge clk);
		setting_wr <= 1'b0;
		override_wr <= 1'b0;
		// operands unqualified now: scramble so nothing leans on them
		setting_op <= ~setting_op;
		override_op <= ~override_op;
	endtask
	// new termination not relied on before the update time
	task automatic settle;
		repeat (UPDATE_CYC + 1) @(posedge clk);
	endtask
endmodule
`default_nettype wire

/* dv/catc_term_ctrl_tb.sv */
// self-checking bench for the command-bus termination control
`timescale 1ns/1ps
`default_nettype none
module catc_term_ctrl_tb;
	import catc_pkg::*;
	logic clk, rst_n, bond, pd, s_wr, o_wr, dis, ckf, csf, busy;
	logic [7:0] s_op, o_op;
	logic [2:0] fld;
	catc_term_en_t en;
	catc_div_t div;
	int fail_count = 0;
	int n_tests = 0;
	int cycles = 0;
	catc_ctrl_model ctl (.clk(clk), .setting_wr(s_wr), .setting_op(s_op), .override_wr(o_wr),
		.override_op(o_op));
	catc_term_ctrl dut (.clk(clk), .rst_n(rst_n), .setting_wr(s_wr), .setting_op(s_op),
		.override_wr(o_wr), .override_op(o_op), .ca_term_bond_option(bond), .power_down(pd),
		.ca_term_value_field(fld), .ca_term_disable_bit(dis), .clk_term_force_bit(ckf),
		.cs_term_force_bit(csf), .term_en(en), .term_div(div), .update_busy(busy));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (exp !== got) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// expected {ca, ck, cs, divider} for code v and override operand o
	function automatic logic [8:0] want(input logic [2:0] v, input logic b, input logic [7:0] o);
		logic on;
		on = (v != VAL_OFF) && (v != VAL_RSVD);
		want[8] = on && b && !o[CA_DIS_POS];
		want[7] = on && (b || o[CK_FORCE_POS]);
		want[6] = on && (b || o[CS_FORCE_POS]);
		want[5:0] = on ? (6'h01 << (v - 3'h1)) : 6'h00;
	endfunction
	task automatic chk_all(input logic [2:0] v, input logic [7:0] o);
		chk("outputs", {1'b0, v, o[CA_DIS_POS], o[CS_FORCE_POS], o[CK_FORCE_POS], want(v, bond, o)},
			{1'b0, fld, dis, csf, ckf, en, div});
	endtask
	// all outputs except update_busy cleared after reset
	task automatic t_reset;
		chk_all(VAL_RESET, OVR_RESET);
	endtask
	// every field code with bond high and no overrides
	task automatic t_codes;
		for (int c = 0; c < 8; c++) begin
			ctl.wr(1'b1, {1'b0, 3'(c), 4'h0});
			ctl.settle();
			chk_all(3'(c), 8'h00);
		end
	endtask
	// update window length, termination held through power-down
	task automatic t_busy;
		pd <= 1'b1;
		ctl.wr(1'b1, {1'b0, VAL_DIV2, 4'h0});
		for (int k = 0; k < 6; k++) begin
			#1 chk("busy", 16'(k < 5), 16'(busy));
			@(posedge clk);
		end
		chk_all(VAL_DIV2, 8'h00);
		pd <= 1'b0;
		@(posedge clk);
		// enter power-down again with termination already on
		pd <= 1'b1;
		repeat (3) @(posedge clk);
		chk_all(VAL_DIV2, 8'h00);
		pd <= 1'b0;
	endtask
	// bond, disable and force bits, field enabled and disabled
	task automatic t_table;
		for (int i = 0; i < 32; i++) begin
			bond <= i[3];
			ctl.wr(1'b1, {1'b0, i[4] ? VAL_DIV5 : VAL_OFF, 4'h0});
			ctl.wr(1'b0, {2'b00, i[2:0], 3'b000});
			ctl.settle();
			chk_all(i[4] ? VAL_DIV5 : VAL_OFF, {2'b00, i[2:0], 3'b000});
		end
	endtask
	task automatic results;
		if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		rst_n = 1'b0;
		bond = 1'b1;
		pd = 1'b0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_codes(); // terminating rank (bond high) set up before any bond-low case
		t_busy();
		t_table();
		results();
	end
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fail_count++;
			results();
		end
	end
endmodule
`default_nettype wire
